// file: core/aso_pkg.sv
// Purpose: Shared constants for the anomaly signalling and override block.
// Assumes: 50 MHz system clock; anomaly slot index equals the anomaly code outside the generic and threshold slots.
// Notes: Group membership lists live here as decode functions.
package aso_pkg;

   // -----------------------------------------------------------------
   // Sizes, classes and override request bits
   // -----------------------------------------------------------------
   localparam int N_SLOT = 256;
   localparam int N_GDIN = 4;
   localparam int N_ATH = 4;
   localparam logic [7:0] GDIN_BASE = 8'hf0;   // Slots holding generic digital anomalies.
   localparam logic [7:0] ATH_BASE = 8'hf4;    // Slots holding analogue threshold anomalies.
   localparam logic [10:0] GDIN_CODE = 11'h2bd; // First generic digital code, 701.
   localparam logic [10:0] ATH_CODE = 11'h12d;  // First analogue threshold code, 301.
   localparam int ATH_OVR_BIT = 15;
   localparam int REQ_ENG = 0;
   localparam int REQ_FULL = 1;
   localparam int REQ_GEN = 2;

   typedef enum logic [1:0] {
      ASO_WARN = 2'h0,
      ASO_UNLOAD = 2'h1,
      ASO_DEACT = 2'h2,
      ASO_ALARM = 2'h3
   } aso_class_t;

   // Generic digital input functions.
   localparam logic [2:0] GEN_PLAIN = 3'h0;
   localparam logic [2:0] GEN_UNLOAD_AFTER_OIL = 3'h1;
   localparam logic [2:0] GEN_DEACT_AFTER_OIL = 3'h2;
   localparam logic [2:0] GEN_ALARM_AFTER_OIL = 3'h3;
   localparam logic [2:0] GEN_UNLOAD_OVERRIDABLE = 3'h4;
   localparam logic [2:0] GEN_DEACT_OVERRIDABLE = 3'h5;
   localparam logic [2:0] GEN_ALARM_OVERRIDABLE = 3'h6;

   // -----------------------------------------------------------------
   // Events, horn and timing
   // -----------------------------------------------------------------
   localparam logic [10:0] OVERRIDE_ON_EVENT = 11'h43a;  // 1082.
   localparam logic [10:0] OVERRIDE_OFF_EVENT = 11'h43b; // 1083.
   localparam logic [9:0] HORN_NEVER = 10'h000;
   localparam logic [9:0] HORN_HOLD = 10'h3e7;           // 999.
   localparam int SEC_MS = 1000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SEC_CYCLES = SEC_MS * 1000000 / CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // Group membership decode
   // -----------------------------------------------------------------
   function automatic logic in_gen(input logic [7:0] c);
      case (c)
         8'h08, 8'h03, 8'h3a, 8'h3c, 8'h04, 8'h01, 8'h38, 8'h3b, 8'h02,
         8'h34, 8'h37, 8'h35, 8'hcb, 8'h6a, 8'h3d, 8'h06, 8'h10: in_gen = 1'b1;
         default: in_gen = 1'b0;
      endcase
   endfunction

   function automatic logic in_eng(input logic [7:0] c);
      case (c)
         8'h16, 8'h15, 8'h27, 8'h28, 8'h32, 8'h60, 8'h63, 8'h12, 8'h11, 8'h76,
         8'h41, 8'h1f, 8'h20, 8'h84, 8'h21, 8'h22, 8'h86, 8'h87, 8'h88, 8'h2b,
         8'h2c, 8'h90, 8'h29, 8'h2a, 8'h8e, 8'h36, 8'h9e, 8'h23, 8'h9f, 8'h05,
         8'h69, 8'h25, 8'h24, 8'h89, 8'h26, 8'h14, 8'h31, 8'hc6, 8'hc7, 8'h3e,
         8'h62: in_eng = 1'b1;
         default: in_eng = 1'b0;
      endcase
   endfunction

   function automatic logic in_spd(input logic [7:0] c);
      case (c)
         8'h11, 8'h12, 8'h76, 8'h63, 8'h03, 8'h3a, 8'h3c, 8'h04, 8'h0b: in_spd = 1'b1;
         default: in_spd = 1'b0;
      endcase
   endfunction

   function automatic logic in_fuel(input logic [7:0] c);
      case (c)
         8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'ha0: in_fuel = 1'b1;
         default: in_fuel = 1'b0;
      endcase
   endfunction

   function automatic logic in_brk(input logic [7:0] c);
      case (c)
         8'h0d, 8'h0e, 8'h17, 8'h18: in_brk = 1'b1;
         default: in_brk = 1'b0;
      endcase
   endfunction

endpackage

// file: core/aso_anomaly_signal_override.sv
// Purpose: Anomaly latching, event logging, signalling outputs and override.
// Assumes: Cause inputs come from detection logic on clk_sys; command and
//    override pins are asynchronous.
// Notes: One event leaves per cycle; simultaneous activations queue as pending.

// Functional notes
// - Each newly active anomaly logs one event carrying its own code.
// - A reset command pulses the reset indication for one second.
// - External horn follows the internal hooter exactly.
// - An acknowledge command pulses the acknowledge indication for one second.
// - Warning, unload, deactivation and alarm outputs show an active anomaly of that class.
// - Severe output shows any active unload, deactivation or alarm.
// - Generator group output ORs the listed generator anomalies.
// - Engine group output ORs the listed engine anomalies.
// - Speed regulator group output ORs speed, frequency and reverse power anomalies.
// - Fuel group output ORs fuel level and water in fuel anomalies.
// - Breaker group output ORs the four breaker close and open failures.
// - Status bits per anomaly, ack and reset in progress, class active.
// - Status bits per class for unacknowledged anomalies.
// - Active overriding requests demote alarms, deactivations and unloads to warnings.
// - Three override requests: engine, full and generator, from pins.
// - Each anomaly has its own override tags; only tagged requests demote it.
// - After oil delay and overridable generic inputs are tagged for engine override.
// - Bit 15 of a threshold configuration tags it for engine override.
// - Engine control unit override indication is received and reported.
// - Log an event when a request activates and when none remains.
// - Horn time 0 never sounds, 999 holds until silenced, else times out.
// - Acknowledged warnings clear when the cause is gone; unacknowledged never.
// - Pin commands act once on the activation edge.
// - Reset clears only anomalies whose cause is gone.
module aso_anomaly_signal_override #(
   parameter int TICK_CYCLES = aso_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Anomaly causes and configuration
   input wire logic [aso_pkg::N_SLOT-1:0] cause_in,
   input wire logic [aso_pkg::N_SLOT*2-1:0] class_cfg,
   input wire logic [aso_pkg::N_SLOT*3-1:0] tag_cfg,
   input wire logic [aso_pkg::N_GDIN*3-1:0] gdin_func,
   input wire logic [aso_pkg::N_ATH*16-1:0] ath_cfg,
   input wire logic [9:0] horn_duration,
   // Operator commands
   input wire logic horn_silence_in,
   input wire logic reset_cmd_in,
   input wire logic ack_cmd_in,
   // Override requests
   input wire logic engine_override_in,
   input wire logic full_override_in,
   input wire logic generator_override_in,
   input wire logic engine_control_unit_override,
   // Event log
   output logic evt_valid,
   output logic [10:0] evt_code,
   // Digital outputs
   output logic reset_indication_out,
   output logic external_horn_out,
   output logic ack_indication_out,
   output logic warning_active_out,
   output logic unload_active_out,
   output logic deactivation_active_out,
   output logic alarm_active_out,
   output logic severe_active_out,
   output logic generator_group_out,
   output logic engine_group_out,
   output logic speed_reg_group_out,
   output logic fuel_group_out,
   output logic breaker_group_out,
   // Internal status
   output logic [aso_pkg::N_SLOT-1:0] anomaly_active,
   output logic ack_in_progress,
   output logic reset_in_progress,
   output logic [3:0] class_active,
   output logic unacked_warnings,
   output logic unacked_unloads,
   output logic unacked_deactivations,
   output logic unacked_alarms,
   output logic [2:0] override_active,
   output logic engine_control_unit_override_out
);
   import aso_pkg::*;

   typedef enum logic [1:0] {
      HORN_OFF = 2'h0,
      HORN_TIMED = 2'h1,
      HORN_HELD = 2'h3
   } aso_horn_t;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Order: reset, ack, engine, full, generator override.
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   logic [4:0] pin_s3;
   logic [4:0] pin_lvl;
   logic [4:0] pin_lvl_q;
   wire [4:0] pin_raw = {generator_override_in, full_override_in, engine_override_in,
                         ack_cmd_in, reset_cmd_in};

   // A level is taken only when the second and third stages agree, which filters
   // a change that is still settling through the chain.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
         pin_s3 <= 5'h00;
         pin_lvl <= 5'h00;
         pin_lvl_q <= 5'h00;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
         pin_lvl_q <= pin_lvl;
      end
   end

   // Commands fire on the activation edge only.
   wire reset_edge = pin_lvl[0] & ~pin_lvl_q[0];
   wire ack_edge = pin_lvl[1] & ~pin_lvl_q[1];
   wire [2:0] ovr_req = pin_lvl[4:2];
   wire [2:0] ovr_req_q = pin_lvl_q[4:2];

   // -----------------------------------------------------------------
   // Effective class and override demotion
   // -----------------------------------------------------------------
   logic [N_SLOT-1:0] active;
   logic [N_SLOT-1:0] acked;
   logic [N_SLOT-1:0] pend;
   logic [N_SLOT-1:0] demote;
   logic [N_SLOT-1:0] cls_warn;
   logic [N_SLOT-1:0] cls_unl;
   logic [N_SLOT-1:0] cls_dea;
   logic [N_SLOT-1:0] cls_alm;
   logic [N_SLOT-1:0] grp_gen;
   logic [N_SLOT-1:0] grp_eng;
   logic [N_SLOT-1:0] grp_spd;
   logic [N_SLOT-1:0] grp_fuel;
   logic [N_SLOT-1:0] grp_brk;

   // Generic slots take their class and engine tag from their own configuration;
   // threshold slots take the engine tag from ath_cfg; all others use the per-slot class and tag words.
   always_comb begin
      logic [1:0] base;
      logic [2:0] tags;
      logic [2:0] fn;
      base = 2'h0;
      tags = 3'h0;
      fn = 3'h0;
      for (int i = 0; i < N_SLOT; i++) begin
         base = class_cfg[i*2 +: 2];
         tags = tag_cfg[i*3 +: 3];
         if (i >= int'(GDIN_BASE) && i < int'(GDIN_BASE) + N_GDIN) begin
            fn = gdin_func[(i - int'(GDIN_BASE))*3 +: 3];
            case (fn)
               GEN_UNLOAD_AFTER_OIL, GEN_UNLOAD_OVERRIDABLE: base = ASO_UNLOAD;
               GEN_DEACT_AFTER_OIL, GEN_DEACT_OVERRIDABLE: base = ASO_DEACT;
               GEN_ALARM_AFTER_OIL, GEN_ALARM_OVERRIDABLE: base = ASO_ALARM;
               default: base = class_cfg[i*2 +: 2];
            endcase
            tags[REQ_ENG] = (fn != GEN_PLAIN);
         end else if (i >= int'(ATH_BASE) && i < int'(ATH_BASE) + N_ATH) begin
            tags[REQ_ENG] = ath_cfg[(i - int'(ATH_BASE))*16 + ATH_OVR_BIT];
         end
         demote[i] = |(tags & ovr_req);
         // A demoted anomaly behaves as a warning in every respect.
         if (demote[i]) begin
            base = ASO_WARN;
         end
         cls_warn[i] = (base == ASO_WARN);
         cls_unl[i] = (base == ASO_UNLOAD);
         cls_dea[i] = (base == ASO_DEACT);
         cls_alm[i] = (base == ASO_ALARM);
         grp_gen[i] = in_gen(8'(i));
         grp_eng[i] = in_eng(8'(i));
         grp_spd[i] = in_spd(8'(i));
         grp_fuel[i] = in_fuel(8'(i));
         grp_brk[i] = in_brk(8'(i));
      end
   end

   // -----------------------------------------------------------------
   // Anomaly latching, acknowledge and reset
   // -----------------------------------------------------------------
   wire [N_SLOT-1:0] new_act = cause_in & ~active;
   // Acknowledged warnings self clear; reset clears any whose cause is gone.
   wire [N_SLOT-1:0] clr_auto = active & ~cause_in & acked & cls_warn;
   wire [N_SLOT-1:0] clr_reset = reset_edge ? (active & ~cause_in) : '0;
   wire [N_SLOT-1:0] next_active = (active & ~clr_auto & ~clr_reset) | new_act;
   wire [N_SLOT-1:0] ack_set = ack_edge ? active : '0;
   // A fresh activation wins over an acknowledge in the same cycle.
   wire [N_SLOT-1:0] next_acked = (acked | ack_set) & next_active & ~new_act;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         active <= '0;
         acked <= '0;
      end else begin
         active <= next_active;
         acked <= next_acked;
      end
   end

   // -----------------------------------------------------------------
   // Event log
   // -----------------------------------------------------------------
   // Lowest pending slot goes first; the queue cannot lose an event because a
   // new activation sets its pending bit after the served bit is cleared.
   function automatic logic [8:0] first_set(input logic [N_SLOT-1:0] v);
      first_set = 9'h000;
      for (int i = N_SLOT - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = {1'b1, 8'(i)};
         end
      end
   endfunction

   function automatic logic [10:0] slot_code(input logic [7:0] s);
      if (s >= GDIN_BASE && s < GDIN_BASE + 8'(N_GDIN)) begin
         slot_code = GDIN_CODE + 11'(s - GDIN_BASE);
      end else if (s >= ATH_BASE && s < ATH_BASE + 8'(N_ATH)) begin
         slot_code = ATH_CODE + 11'(s - ATH_BASE);
      end else begin
         slot_code = {3'h0, s};
      end
   endfunction

   logic ovr_on_pend;
   logic ovr_off_pend;
   wire [8:0] pick = first_set(pend);
   wire serve_ovr_on = ovr_on_pend;
   wire serve_ovr_off = ovr_off_pend & ~ovr_on_pend;
   wire serve_slot = pick[8] & ~ovr_on_pend & ~ovr_off_pend;
   wire [N_SLOT-1:0] served = serve_slot ? (N_SLOT'(1) << pick[7:0]) : '0;
   wire ovr_rise = |(ovr_req & ~ovr_req_q);
   wire ovr_none = (ovr_req == 3'h0) && (ovr_req_q != 3'h0);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pend <= '0;
         ovr_on_pend <= 1'b0;
         ovr_off_pend <= 1'b0;
         evt_valid <= 1'b0;
         evt_code <= 11'h000;
      end else begin
         pend <= (pend & ~served) | new_act;
         ovr_on_pend <= (ovr_on_pend & ~serve_ovr_on) | ovr_rise;
         ovr_off_pend <= (ovr_off_pend & ~serve_ovr_off) | ovr_none;
         evt_valid <= serve_ovr_on | serve_ovr_off | serve_slot;
         if (serve_ovr_on) begin
            evt_code <= OVERRIDE_ON_EVENT;
         end else if (serve_ovr_off) begin
            evt_code <= OVERRIDE_OFF_EVENT;
         end else if (serve_slot) begin
            evt_code <= slot_code(pick[7:0]);
         end
      end
   end

   // -----------------------------------------------------------------
   // One second tick and indication pulses
   // -----------------------------------------------------------------
   logic [25:0] presc;
   logic [25:0] rst_cnt;
   logic [25:0] ack_cnt;
   wire tick = (presc == 26'(TICK_CYCLES - 1));
   // A new command reloads the full second, so the pulse is always whole.
   wire [25:0] next_rst_cnt = reset_edge ? 26'(TICK_CYCLES) :
                              (rst_cnt != 26'h0 ? rst_cnt - 26'h1 : 26'h0);
   wire [25:0] next_ack_cnt = ack_edge ? 26'(TICK_CYCLES) :
                              (ack_cnt != 26'h0 ? ack_cnt - 26'h1 : 26'h0);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         presc <= 26'h0;
         rst_cnt <= 26'h0;
         ack_cnt <= 26'h0;
         reset_indication_out <= 1'b0;
         ack_indication_out <= 1'b0;
      end else begin
         presc <= tick ? 26'h0 : presc + 26'h1;
         rst_cnt <= next_rst_cnt;
         ack_cnt <= next_ack_cnt;
         reset_indication_out <= (next_rst_cnt != 26'h0);
         ack_indication_out <= (next_ack_cnt != 26'h0);
      end
   end

   // -----------------------------------------------------------------
   // Hooter
   // -----------------------------------------------------------------
   aso_horn_t horn_st;
   aso_horn_t next_horn_st;
   logic [9:0] horn_sec;
   logic [9:0] next_horn_sec;
   wire any_new = |new_act;

   // Silence wins over a time-out; a new activation restarts the hold time.
   always_comb begin
      next_horn_st = horn_st;
      next_horn_sec = horn_sec;
      if (any_new && horn_duration != HORN_NEVER) begin
         next_horn_st = (horn_duration == HORN_HOLD) ? HORN_HELD : HORN_TIMED;
         next_horn_sec = horn_duration;
      end else begin
         case (horn_st)
            HORN_TIMED: begin
               if (horn_silence_in || horn_sec == 10'h000) begin
                  next_horn_st = HORN_OFF;
               end else if (tick) begin
                  next_horn_sec = horn_sec - 10'h001;
                  if (horn_sec == 10'h001) begin
                     next_horn_st = HORN_OFF;
                  end
               end
            end
            HORN_HELD: begin
               if (horn_silence_in) begin
                  next_horn_st = HORN_OFF;
               end
            end
            default: next_horn_st = HORN_OFF;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         horn_st <= HORN_OFF;
         horn_sec <= 10'h000;
         external_horn_out <= 1'b0;
      end else begin
         horn_st <= next_horn_st;
         horn_sec <= next_horn_sec;
         external_horn_out <= (next_horn_st != HORN_OFF);
      end
   end

   // -----------------------------------------------------------------
   // Class, group and status outputs
   // -----------------------------------------------------------------
   wire [3:0] next_cls = {|(next_active & cls_alm), |(next_active & cls_dea),
                          |(next_active & cls_unl), |(next_active & cls_warn)};
   wire [N_SLOT-1:0] next_unack = next_active & ~next_acked;

   // Class, group and unacknowledged outputs are registered from next state so they line up with the latches.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         class_active <= 4'h0;
         severe_active_out <= 1'b0;
         generator_group_out <= 1'b0;
         engine_group_out <= 1'b0;
         speed_reg_group_out <= 1'b0;
         fuel_group_out <= 1'b0;
         breaker_group_out <= 1'b0;
         unacked_warnings <= 1'b0;
         unacked_unloads <= 1'b0;
         unacked_deactivations <= 1'b0;
         unacked_alarms <= 1'b0;
         override_active <= 3'h0;
         engine_control_unit_override_out <= 1'b0;
      end else begin
         class_active <= next_cls;
         severe_active_out <= |next_cls[3:1];
         generator_group_out <= |(next_active & grp_gen);
         engine_group_out <= |(next_active & grp_eng);
         speed_reg_group_out <= |(next_active & grp_spd);
         fuel_group_out <= |(next_active & grp_fuel);
         breaker_group_out <= |(next_active & grp_brk);
         unacked_warnings <= |(next_unack & cls_warn);
         unacked_unloads <= |(next_unack & cls_unl);
         unacked_deactivations <= |(next_unack & cls_dea);
         unacked_alarms <= |(next_unack & cls_alm);
         override_active <= ovr_req;
         engine_control_unit_override_out <= engine_control_unit_override;
      end
   end

   assign warning_active_out = class_active[0];
   assign unload_active_out = class_active[1];
   assign deactivation_active_out = class_active[2];
   assign alarm_active_out = class_active[3];
   assign anomaly_active = active;
   assign ack_in_progress = ack_indication_out;
   assign reset_in_progress = reset_indication_out;

endmodule

// file: verification/aso_checker.sv
// Purpose: Port-level assertions for the anomaly signalling block.
// Assumes: TICK_CYCLES of at least 16 in the bench.
// Notes: Attached by bind from the bench top.
module aso_checker (
   // Clock, reset and pins
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ack_cmd_in,
   input wire logic [9:0] horn_duration,
   // Watched outputs
   input wire logic evt_valid,
   input wire logic [10:0] evt_code,
   input wire logic external_horn_out,
   input wire logic ack_indication_out,
   input wire logic reset_indication_out,
   input wire logic ack_in_progress,
   input wire logic [3:0] class_active,
   input wire logic warning_active_out,
   input wire logic unload_active_out,
   input wire logic deactivation_active_out,
   input wire logic alarm_active_out,
   input wire logic severe_active_out,
   input wire logic breaker_group_out,
   input wire logic fuel_group_out,
   input wire logic [255:0] anomaly_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // A pulse must stand well beyond a couple of cycles, so a stuck counter shows.
   sequence s_ack8; ack_indication_out [*8]; endsequence
   sequence s_rst8; reset_indication_out [*8]; endsequence
   AST_ACK_PULSE: assert property ($rose(ack_indication_out) |-> s_ack8 ##1 s_ack8)
      else $error("ack pulse too short");
   AST_RST_PULSE: assert property ($rose(reset_indication_out) |-> s_rst8 ##1 s_rst8)
      else $error("reset pulse too short");
   AST_CMD: assert property ($rose(ack_cmd_in) ##1 ack_cmd_in [*4] |-> ##[1:5] ack_indication_out)
      else $error("ack command not executed");
   AST_ACKST: assert property (ack_in_progress == ack_indication_out)
      else $error("ack status differs from output");
   AST_CLASS: assert property ({alarm_active_out, deactivation_active_out, unload_active_out,
      warning_active_out} == class_active)
      else $error("class outputs differ from status");
   AST_SEVERE: assert property (severe_active_out == (|class_active[3:1]))
      else $error("severe output wrong");
   AST_BRK: assert property (breaker_group_out == (anomaly_active[8'h0d] | anomaly_active[8'h0e]
      | anomaly_active[8'h17] | anomaly_active[8'h18]))
      else $error("breaker group wrong");
   AST_FUEL: assert property (fuel_group_out == (|anomaly_active[8'h1e:8'h19]
      | anomaly_active[8'ha0]))
      else $error("fuel group wrong");
   AST_HORN: assert property (horn_duration == 10'h000 |-> !external_horn_out)
      else $error("horn sounded with zero duration");
   AST_EVT: assert property ($rose(anomaly_active[8'h0d]) |-> ##[1:8]
      (evt_valid && evt_code == 11'h00d))
      else $error("no event for new anomaly");
endmodule

// file: verification/aso_plant.sv
// Purpose: Plant side pins: command switches, override switches, CAN flag.
// Assumes: Requests come from the bench as one bit each.
// Notes: Pins move just after a rising edge, like a slow contact.
module aso_plant (
   input wire logic clk_sys,
   input wire logic [5:0] req,
   output logic [5:0] pins
);
   // Bits: reset, ack, engine, full, generator override, engine unit flag.
   always_ff @(posedge clk_sys) begin
      pins <= req;
   end
endmodule

// file: verification/aso_anomaly_signal_override_test.sv
// Purpose: Directed scenarios for anomaly signalling and override.
// Assumes: TICK_CYCLES set to 20 for short pulses.
// Notes: Horn duration stays zero until the last scenario holds the horn on.
module aso_anomaly_signal_override_test;
   timeunit 1ns;
   timeprecision 1ps;
   import aso_pkg::*;
   logic clk_sys, rst_b, horn_silence_in, evt_valid, reset_indication_out, external_horn_out;
   logic ack_indication_out, warning_active_out, unload_active_out, deactivation_active_out;
   logic alarm_active_out, severe_active_out, generator_group_out, engine_group_out;
   logic speed_reg_group_out, fuel_group_out, breaker_group_out, ack_in_progress;
   logic reset_in_progress, unacked_warnings, unacked_unloads, unacked_deactivations;
   logic unacked_alarms, engine_control_unit_override_out;
   logic [10:0] evt_code;
   logic [3:0] class_active;
   logic [2:0] override_active;
   logic [5:0] req, pins;
   logic [N_SLOT-1:0] cause_in, anomaly_active;
   logic [N_SLOT*2-1:0] class_cfg;
   logic [N_SLOT*3-1:0] tag_cfg;
   logic [9:0] horn_duration;
   logic [N_GDIN*3-1:0] gdin_func;
   logic [N_ATH*16-1:0] ath_cfg;
   int n_errors = 0, compares = 0, cycles = 0;
   aso_plant u_aso_plant (.clk_sys, .req, .pins);
   aso_anomaly_signal_override #(.TICK_CYCLES(20)) u_aso_anomaly_signal_override (.clk_sys,
      .rst_b, .cause_in, .class_cfg, .tag_cfg, .gdin_func, .ath_cfg,
      .horn_duration, .horn_silence_in, .reset_cmd_in(pins[0]), .ack_cmd_in(pins[1]),
      .engine_override_in(pins[2]), .full_override_in(pins[3]),
      .generator_override_in(pins[4]), .engine_control_unit_override(pins[5]), .evt_valid,
      .evt_code, .reset_indication_out, .external_horn_out, .ack_indication_out,
      .warning_active_out, .unload_active_out, .deactivation_active_out, .alarm_active_out,
      .severe_active_out, .generator_group_out, .engine_group_out, .speed_reg_group_out,
      .fuel_group_out, .breaker_group_out, .anomaly_active, .ack_in_progress,
      .reset_in_progress, .class_active, .unacked_warnings, .unacked_unloads,
      .unacked_deactivations, .unacked_alarms, .override_active,
      .engine_control_unit_override_out);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // A hang is cut after a budget far above the scenarios' length.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   task automatic chk_code(input logic [10:0] got, input logic [10:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: event %h not %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Events queue one per cycle, so the wait is bounded but generous.
   task automatic wait_evt(input logic [10:0] code);
      int i;
      for (i = 0; i < 30 && evt_valid !== 1'b1; i++) cyc(1);
      chk_code(evt_code, code);
      cyc(1);
   endtask
   task automatic pin(input int b);
      req[b] = 1'b1;
      cyc(6);
      req[b] = 1'b0;
      cyc(2);
   endtask
   task automatic t_raise();
      cause_in[8'h08] = 1'b1;
      cause_in[8'h0d] = 1'b1;
      cause_in[8'hf0] = 1'b1;
      cause_in[8'hf4] = 1'b1;
      wait_evt(11'h008);
      wait_evt(11'h00d);
      wait_evt(GDIN_CODE);
      wait_evt(ATH_CODE);
      chk(generator_group_out, 1'b1);
      chk(alarm_active_out, 1'b1);
      chk(warning_active_out, 1'b1);
      chk(severe_active_out, 1'b1);
      chk(unacked_alarms, 1'b1);
      chk(external_horn_out, 1'b0);
   endtask
   task automatic t_override();
      req[2] = 1'b1;
      wait_evt(OVERRIDE_ON_EVENT);
      cyc(2);
      chk(alarm_active_out, 1'b0);
      chk(severe_active_out, 1'b0);
      req[2] = 1'b0;
      wait_evt(OVERRIDE_OFF_EVENT);
      cyc(2);
      chk(alarm_active_out, 1'b1);
   endtask
   task automatic t_ack();
      cause_in[8'h08] = 1'b0;
      cyc(3);
      chk(anomaly_active[8'h08], 1'b1);
      pin(1);
      chk(ack_indication_out, 1'b1);
      chk(unacked_alarms, 1'b0);
      chk(anomaly_active[8'h08], 1'b0);
      cyc(15);
      chk(ack_indication_out, 1'b1);
      cyc(4);
      chk(ack_indication_out, 1'b0);
   endtask
   task automatic t_reset();
      pin(0);
      chk(reset_indication_out, 1'b1);
      chk(anomaly_active[8'h0d], 1'b1);
      cause_in[8'h0d] = 1'b0;
      cyc(20);
      pin(0);
      chk(anomaly_active[8'h0d], 1'b0);
      chk(breaker_group_out, 1'b0);
      req[5] = 1'b1;
      cyc(3);
      chk(engine_control_unit_override_out, 1'b1);
      horn_duration = HORN_HOLD;
      cause_in[8'h0d] = 1'b1;
      cyc(2);
      chk(external_horn_out, 1'b1);
      horn_silence_in = 1'b1;
      cyc(2);
      chk(external_horn_out, 1'b0);
   endtask
   initial begin
      rst_b = 1'b0;
      horn_silence_in = 1'b0;
      horn_duration = HORN_NEVER;
      req = 6'h00;
      cause_in = '0;
      class_cfg = '0;
      tag_cfg = '0;
      class_cfg[27:26] = ASO_ALARM;
      class_cfg[489:488] = ASO_ALARM;
      gdin_func = 12'(GEN_ALARM_OVERRIDABLE);
      ath_cfg = '0;
      ath_cfg[ATH_OVR_BIT] = 1'b1;
      tag_cfg[39] = 1'b1;
      cyc(3);
      rst_b = 1'b1;
      cyc(2);
      t_raise();
      t_override();
      t_ack();
      t_reset();
      wrap_up();
   end
endmodule
bind aso_anomaly_signal_override aso_checker u_aso_checker (.clk_sys, .rst_b, .ack_cmd_in,
   .horn_duration, .evt_valid, .evt_code, .external_horn_out, .ack_indication_out,
   .reset_indication_out, .ack_in_progress, .class_active, .warning_active_out,
   .unload_active_out, .deactivation_active_out, .alarm_active_out, .severe_active_out,
   .breaker_group_out, .fuel_group_out, .anomaly_active);
